/* File: i2c_port_expander.sv */
// two-wire eight-bit open-drain port expander: serial engine, port latch, change alert
module i2c_port_expander
	import i2c_expander_pkg::*;
#(
	parameter logic [3:0] ADDR_HIGH = ADDR_FIXED
) (
	// system clock and reset
	input  wire logic              clk_sys,
	input  wire logic              reset,
	// link clock for the serial engine
	input  wire logic              linkClk,
	// serial bus, open drain data
	input  wire logic              sclIn,
	input  wire logic              sdaIn,
	output logic                   sdaOut,
	output logic                   sdaOe,
	// address select straps
	input  wire logic              addr_select_bit0,
	input  wire logic              addr_select_bit1,
	input  wire logic              addr_select_bit2,
	// port pins, open drain
	input  wire logic [PORT_W-1:0] io_port_pins,
	output logic [PORT_W-1:0]      portOut,
	output logic [PORT_W-1:0]      portOe,
	// change alert, active low, open drain
	output logic                   alertOut_n,
	output logic                   alertOe
);

	// ------------------------------------------------------------
	// link domain synchronisers
	// ------------------------------------------------------------
	logic [1:0]        rstL_r;
	logic [2:0]        scl_r;
	logic [2:0]        sda_r;
	logic [PORT_W-1:0] pinsL1_r, pinsL_r;
	logic [2:0]        adrS1_r, adrS_r;
	logic              resetL;

	always_ff @(posedge linkClk) begin
		rstL_r   <= {rstL_r[0], reset};
		scl_r    <= {scl_r[1:0], sclIn};
		sda_r    <= {sda_r[1:0], sdaIn};
		pinsL1_r <= io_port_pins;
		pinsL_r  <= pinsL1_r;
		adrS1_r  <= {addr_select_bit2, addr_select_bit1, addr_select_bit0};
		adrS_r   <= adrS1_r;
	end
	assign resetL = rstL_r[1];

	// edges and conditions look only at settled stages 1 and 2
	logic sclRise, sclFall, startCond, stopCond;
	assign sclRise   = scl_r[1] & ~scl_r[2];
	assign sclFall   = ~scl_r[1] & scl_r[2];
	assign startCond = scl_r[1] & scl_r[2] & sda_r[2] & ~sda_r[1];
	assign stopCond  = scl_r[1] & scl_r[2] & ~sda_r[2] & sda_r[1];

	// ------------------------------------------------------------
	// serial engine
	// ------------------------------------------------------------
	linkState_t        state_r;
	logic [2:0]        bitCnt_r;
	logic [7:0]        rxShift_r;
	logic [7:0]        txShift_r;
	logic [7:0]        snap_r;
	logic [7:0]        sentByte_r;
	logic [7:0]        latchByte_r;
	logic              sdaDrive_r;
	logic              nackSeen_r;
	logic              readDir_r;
	logic              bitSeen_r;
	linkEvt_t          evtTgl_r;
	logic [6:0]        myAddr;

	assign myAddr = {ADDR_HIGH, adrS_r};

	always_ff @(posedge linkClk) begin
		if (resetL) begin
			state_r     <= ST_IDLE;
			bitCnt_r    <= FIRST_BIT;
			rxShift_r   <= 8'h00;
			txShift_r   <= 8'hFF;
			snap_r      <= 8'hFF;
			sentByte_r  <= 8'hFF;
			latchByte_r <= LATCH_RESET;
			sdaDrive_r  <= 1'b0;
			nackSeen_r  <= 1'b0;
			readDir_r   <= 1'b0;
			bitSeen_r   <= 1'b0;
			evtTgl_r    <= '0;
		end else if (stopCond) begin
			state_r       <= ST_IDLE;
			sdaDrive_r    <= 1'b0;
			evtTgl_r.stop <= ~evtTgl_r.stop;
		end else if (startCond) begin
			state_r    <= ST_ADDR;
			bitCnt_r   <= FIRST_BIT;
			bitSeen_r  <= 1'b0;
			sdaDrive_r <= 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					sdaDrive_r <= 1'b0;
				end
				ST_ADDR: begin
					if (sclRise) begin
						rxShift_r <= {rxShift_r[6:0], sda_r[1]};
						bitSeen_r <= 1'b1;
					end
					// the clock fall that closes the start condition carries no bit
					if (sclFall && bitSeen_r) begin
						bitCnt_r <= bitCnt_r + 3'h1;
						if (bitCnt_r == LAST_BIT) begin
							if (rxShift_r[7:1] == myAddr) begin
								state_r    <= ST_ADDRACK;
								readDir_r  <= rxShift_r[0];
								sdaDrive_r <= 1'b1;
							end else begin
								state_r <= ST_IDLE;
							end
						end
					end
				end
				ST_ADDRACK: begin
					if (sclRise && readDir_r) begin
						snap_r <= pinsL_r;
					end
					if (sclFall) begin
						bitCnt_r <= FIRST_BIT;
						if (readDir_r) begin
							state_r    <= ST_RDDATA;
							sentByte_r <= snap_r;
							sdaDrive_r <= ~snap_r[7];
							txShift_r  <= {snap_r[6:0], 1'b1};
						end else begin
							state_r    <= ST_WRDATA;
							sdaDrive_r <= 1'b0;
						end
					end
				end
				ST_WRDATA: begin
					if (sclRise) begin
						rxShift_r <= {rxShift_r[6:0], sda_r[1]};
					end
					if (sclFall) begin
						bitCnt_r <= bitCnt_r + 3'h1;
						if (bitCnt_r == LAST_BIT) begin
							state_r    <= ST_WRACK;
							sdaDrive_r <= 1'b1;
						end
					end
				end
				ST_WRACK: begin
					if (sclFall) begin
						latchByte_r    <= rxShift_r;
						evtTgl_r.write <= ~evtTgl_r.write;
						state_r        <= ST_WRDATA;
						bitCnt_r       <= FIRST_BIT;
						sdaDrive_r     <= 1'b0;
					end
				end
				ST_RDDATA: begin
					if (sclFall) begin
						bitCnt_r <= bitCnt_r + 3'h1;
						if (bitCnt_r == LAST_BIT) begin
							state_r    <= ST_RDACK;
							sdaDrive_r <= 1'b0;
						end else begin
							sdaDrive_r <= ~txShift_r[7];
							txShift_r  <= {txShift_r[6:0], 1'b1};
						end
					end
				end
				ST_RDACK: begin
					if (sclRise) begin
						nackSeen_r        <= sda_r[1];
						snap_r            <= pinsL_r;
						evtTgl_r.release_ <= ~evtTgl_r.release_;
					end
					if (sclFall) begin
						bitCnt_r <= FIRST_BIT;
						if (nackSeen_r) begin
							state_r <= ST_IDLE;
						end else begin
							state_r    <= ST_RDDATA;
							sentByte_r <= snap_r;
							sdaDrive_r <= ~snap_r[7];
							txShift_r  <= {snap_r[6:0], 1'b1};
						end
					end
				end
			endcase
		end
	end

	assign sdaOut = 1'b0;
	assign sdaOe  = sdaDrive_r;

	// ------------------------------------------------------------
	// system domain: event crossing
	// ------------------------------------------------------------
	// toggles with data words held still in the link domain; the words only
	// change half a serial clock later, far beyond the two-stage delay here
	linkEvt_t          evtS1_r, evtS2_r, evtS3_r;
	logic [PORT_W-1:0] pinsS1_r, pinsS_r;
	logic              relPulse, wrPulse, stopPulse;

	always_ff @(posedge clk_sys) begin
		evtS1_r  <= evtTgl_r;
		evtS2_r  <= evtS1_r;
		evtS3_r  <= evtS2_r;
		pinsS1_r <= io_port_pins;
		pinsS_r  <= pinsS1_r;
	end
	assign relPulse  = evtS2_r.release_ ^ evtS3_r.release_;
	assign wrPulse   = evtS2_r.write ^ evtS3_r.write;
	assign stopPulse = evtS2_r.stop ^ evtS3_r.stop;

	// ------------------------------------------------------------
	// port latch, reference and alert
	// ------------------------------------------------------------
	logic [PORT_W-1:0] latch_r;
	logic [PORT_W-1:0] ref_r;
	logic              hold_r;
	logic              alert_r;
	logic              mismatch;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			latch_r <= LATCH_RESET;
		end else if (wrPulse) begin
			latch_r <= latchByte_r;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ref_r <= pinsS_r;
		end else if (relPulse) begin
			ref_r <= sentByte_r;
		end else if (wrPulse) begin
			ref_r <= pinsS_r;
		end
	end

	// a release arriving with the stop wins, so the alert cannot slip out early
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			hold_r <= 1'b0;
		end else if (relPulse) begin
			hold_r <= 1'b1;
		end else if (stopPulse) begin
			hold_r <= 1'b0;
		end
	end

	// only pins with a released latch act as inputs
	assign mismatch = |((pinsS_r ^ ref_r) & latch_r);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			alert_r <= 1'b0;
		end else begin
			alert_r <= mismatch & ~hold_r & ~relPulse;
		end
	end

	assign portOut    = '0;
	assign portOe     = ~latch_r;
	assign alertOut_n = 1'b0;
	assign alertOe    = alert_r;

endmodule : i2c_port_expander

/* File: i2c_expander_pkg.sv */
// shared constants and types of the two-wire port expander
package i2c_expander_pkg;

	// ------------------------------------------------------------
	// widths and address
	// ------------------------------------------------------------
	localparam int          PORT_W       = 8;
	localparam int          SYNC_STAGES  = 2;
	localparam logic [3:0]  ADDR_FIXED   = 4'h4;
	localparam logic [7:0]  LATCH_RESET  = 8'hFF;
	localparam logic [2:0]  LAST_BIT     = 3'h7;
	localparam logic [2:0]  FIRST_BIT    = 3'h0;

	// ------------------------------------------------------------
	// serial engine states, one-hot
	// ------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE    = 7'h01,
		ST_ADDR    = 7'h02,
		ST_ADDRACK = 7'h04,
		ST_WRDATA  = 7'h08,
		ST_WRACK   = 7'h10,
		ST_RDDATA  = 7'h20,
		ST_RDACK   = 7'h40
	} linkState_t;

	// toggles that carry events from the link domain to the system domain
	typedef struct packed {
		logic release_;
		logic write;
		logic stop;
	} linkEvt_t;

endpackage : i2c_expander_pkg

/* File: i2c_bus_master_model.sv */
// behavioural two-wire bus master that drives the expander's serial lines
module i2c_bus_master_model (
	// timing reference
	input  wire logic clk,
	// bus lines
	output logic      sclLine,
	output logic      pullSda,
	input  wire logic sdaLine
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sclLine = 1'b1;
		pullSda = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt

	// ----
	// bus steps
	// ----
	// data moves well after the clock fall so the device never sees it as start or stop
	task automatic bitX(input logic b, output logic s);
		wt(5);
		pullSda = !b;
		wt(25);
		sclLine = 1'b1;
		wt(20);
		s = sdaLine;
		sclLine = 1'b0;
	endtask : bitX

	task automatic start();
		wt(5);
		pullSda = 1'b0;
		wt(25);
		sclLine = 1'b1;
		wt(20);
		pullSda = 1'b1;
		wt(20);
		sclLine = 1'b0;
	endtask : start

	task automatic stop();
		wt(5);
		pullSda = 1'b1;
		wt(25);
		sclLine = 1'b1;
		wt(20);
		pullSda = 1'b0;
		wt(20);
	endtask : stop

	task automatic sendByte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bitX(d[i], s);
		bitX(1'b1, s);
		ack = !s;
	endtask : sendByte

	task automatic recvByte(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bitX(1'b1, d[i]);
		bitX(!more, s);
	endtask : recvByte
endmodule : i2c_bus_master_model

/* File: i2c_port_expander_chk.sv */
// assertion checker on the port expander's ports
module i2c_port_expander_chk (
	// clocks and reset
	input wire logic       clk_sys,
	input wire logic       reset,
	input wire logic       linkClk,
	// watched ports
	input wire logic       sclIn,
	input wire logic       sdaIn,
	input wire logic       sdaOut,
	input wire logic       sdaOe,
	input wire logic [7:0] portOut,
	input wire logic [7:0] portOe,
	input wire logic       alertOut_n,
	input wire logic       alertOe
);
	logic busy_r;
	logic held_r;

	// ----
	// transfer state seen on the raw lines
	// ----
	always_ff @(posedge clk_sys) begin
		if (reset || (sclIn && $rose(sdaIn))) busy_r <= 1'b0;
		else if (sclIn && $fell(sdaIn)) busy_r <= 1'b1;
	end
	// only a release while the clock is high counts, so a write never arms it
	always_ff @(posedge clk_sys) begin
		if (reset || (sclIn && $rose(sdaIn))) held_r <= 1'b0;
		else if (busy_r && sclIn && $fell(alertOe)) held_r <= 1'b1;
	end

	sequence leaveReset;
		$fell(reset);
	endsequence
	sequence sdaTaken;
		$rose(sdaOe);
	endsequence

	AST_RESET: assert property (@(posedge clk_sys) disable iff (reset)
		leaveReset |-> (portOe == 8'h00 && !alertOe) [*4]) else $error("reset state lost");
	AST_OPEN: assert property (@(posedge clk_sys) disable iff (reset)
		!sdaOut && portOut == 8'h00 && !alertOut_n) else $error("open drain level");
	AST_PORT_SCL: assert property (@(posedge clk_sys) disable iff (reset)
		$changed(portOe) |-> !sclIn) else $error("latch moved with clock high");
	AST_PORT_BUSY: assert property (@(posedge clk_sys) disable iff (reset)
		$changed(portOe) |-> busy_r) else $error("latch moved outside transfer");
	AST_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
		held_r |-> !$rose(alertOe)) else $error("alert back before stop");
	AST_IDLE: assert property (@(posedge clk_sys) disable iff (reset)
		!busy_r |-> !sdaOe) else $error("data driven on idle bus");
	AST_SDA_SCL: assert property (@(posedge linkClk) disable iff (reset)
		$changed(sdaOe) |-> !sclIn) else $error("data moved with clock high");
	AST_SDA_REL: assert property (@(posedge linkClk) disable iff (reset)
		sdaTaken |-> ##[1:600] !sdaOe) else $error("data line never released");
endmodule : i2c_port_expander_chk

/* File: testbench.sv */
// self-checking bench of the two-wire port expander
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk_sys;
	logic       linkClk;
	logic       reset;
	logic [2:0] addrSel;
	logic [7:0] extDrv;
	logic [7:0] d1;
	logic [7:0] d2;
	logic       ack;
	logic       sclLine;
	logic       pullSda;
	logic       sdaOut;
	logic       sdaOe;
	logic       alertOut_n;
	logic       alertOe;
	logic [7:0] portOut;
	logic [7:0] portOe;
	wire logic       sdaLine;
	wire logic [7:0] pins;
	int         failures;
	int         nCompared;

	// pull-ups on both the data line and every port pin
	assign sdaLine = !(pullSda || sdaOe);
	assign pins = extDrv & ~portOe;

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		linkClk = 1'b0;
		#3.7;
		forever #6 linkClk = ~linkClk;
	end

	i2c_port_expander u_dut (.clk_sys(clk_sys), .reset(reset), .linkClk(linkClk),
		.sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.addr_select_bit0(addrSel[0]), .addr_select_bit1(addrSel[1]),
		.addr_select_bit2(addrSel[2]), .io_port_pins(pins), .portOut(portOut),
		.portOe(portOe), .alertOut_n(alertOut_n), .alertOe(alertOe));
	i2c_bus_master_model u_mst (.clk(clk_sys), .sclLine(sclLine), .pullSda(pullSda),
		.sdaLine(sdaLine));

	// ----
	// shared tasks
	// ----
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wt

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		nCompared++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic waitAlert(input logic exp);
		for (int i = 0; i < 60 && alertOe !== exp; i++) wt(1);
		check({7'h00, alertOe}, {7'h00, exp});
	endtask : waitAlert

	task automatic closeOut();
		$display("compared %0d, mismatches %0d", nCompared, failures);
		if (failures == 0 && nCompared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : closeOut

	task automatic wrAck(input logic [7:0] d, input logic exp);
		u_mst.sendByte(d, ack);
		check({7'h00, ack}, {7'h00, exp});
	endtask : wrAck

	// ----
	// scenarios
	// ----
	task automatic runReset();
		reset = 1'b1;
		repeat (10) @(posedge clk_sys);
		#1;
		reset = 1'b0;
		wt(20);
		check(portOe, 8'h00);
		check({7'h00, alertOe}, 8'h00);
	endtask : runReset

	task automatic runWrite();
		u_mst.start();
		wrAck(8'h4A, 1'b1);
		wrAck(8'h0F, 1'b1);
		wrAck(8'hA5, 1'b1);
		u_mst.stop();
		wt(10);
		check(portOe, 8'h5A);
		u_mst.start();
		wrAck(8'h4C, 1'b0);
		wrAck(8'h00, 1'b0);
		u_mst.stop();
		check(portOe, 8'h5A);
	endtask : runWrite

	// pins move once in each read byte; the second byte tells the snapshot moment
	task automatic runRead();
		u_mst.start();
		wrAck(8'h4A, 1'b1);
		wrAck(8'hFF, 1'b1);
		wrAck(8'hFF, 1'b1);
		u_mst.stop();
		check(portOe, 8'h00);
		waitAlert(1'b0);
		extDrv = 8'h3C;
		waitAlert(1'b1);
		u_mst.start();
		wrAck(8'h4B, 1'b1);
		fork
			begin
				u_mst.recvByte(1'b1, d1);
				u_mst.recvByte(1'b0, d2);
			end
			begin
				wt(100);
				extDrv = 8'hC3;
				wt(450);
				extDrv = 8'h0F;
			end
		join
		check(d1, 8'h3C);
		check(d2, 8'hC3);
		check({7'h00, alertOe}, 8'h00);
		u_mst.stop();
		waitAlert(1'b1);
	endtask : runRead

	initial begin
		failures = 0;
		nCompared = 0;
		extDrv = 8'hFF;
		addrSel = 3'h5;
		runReset();
		runWrite();
		runRead();
		closeOut();
	end
	initial begin
		#100000;
		failures++;
		closeOut();
	end
endmodule : testbench

bind i2c_port_expander i2c_port_expander_chk u_chk (.clk_sys(clk_sys), .reset(reset),
	.linkClk(linkClk), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
	.portOut(portOut), .portOe(portOe), .alertOut_n(alertOut_n), .alertOe(alertOe));
